// ==== hdl/swc_wiper_cmd.sv ====
// Serial command unit of a 1024-position digital potentiometer: serial frame
// capture on the link clock, decode and execution on the core clock.
// Assumes the serial clock stops while chip select is high, so the captured
// frame and bit count stand still when the core samples them.
//
// Overview of operation
// R1: Code 0xB with address zero loads frame data into the wiper position register.
// R2: Code 0x2 copies the wiper position into nonvolatile store word zero.
// R3: A store lasts 25 ms; incoming frames are ignored meanwhile.
// R4: Completion of a store pulses the ready output low.
// R5: Wiper value zero means terminal B; wiper rewrites are unlimited.
// R6: After reset the wiper reloads from the store, which starts at midscale.
// R7: Codes 0x1 and 0x8 reload the wiper from store word zero.
// R8: Preset low forces midscale; its rising edge reloads from the store.
// R9: A chip-select strobe without data repeats step or shift instructions.
// R10: An empty chip-select strobe repeats the last command, except after power-up.
// R11: Write-protect low blocks wiper changes except reloads and preset.
// R12: Host should send a no-operation before releasing write-protect.
// R13: Serial output driver is off whenever chip select is high.
// R14: Frames are 24 bits, MSB first, chip select low throughout.
// R15: Frame is decoded only at chip-select rising edge into command, address, data.
// R16: Frames whose bit count modulo 256 is a nonzero multiple of 24 are accepted; others are not.
// R17: Bit count not a multiple of 24 at chip-select rise resets the count.
// R18: Serial modes supported are phase 1 polarity 1 and phase 0 polarity 0.
// R19: Codes 10 and 9 read back wiper and store; others pass data through.
// R20: Otherwise the output shifts the previous frame's word during the next frame.
// R21: Two chained devices take 48 bits, far device first, then chip select rises.
// R22: Halve 4/5, decrement 6/7, double 12/13, increment 14/15.
// R23: Command in top four bits, address next, wiper value in low ten bits.
// R24: Ready also pulses after user store, reset reload, readbacks and preset.
// R25: Readback data appears on the serial output during the following frame.
// R26: Increment and decrement saturate at zero and full scale.
`timescale 1ns/10ps

module swc_wiper_cmd #(
	parameter int STORE_CYCLES = swc_pkg::STORE_CYCLES
) (
	// Core clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Serial link
	input wire logic sclk,
	input wire logic csn,
	input wire logic sdi,
	output logic sdo_o,
	output logic sdo_oe_n,
	// Control pins
	input wire logic preset_strobe_n,
	input wire logic write_protect_n,
	// Ready, open drain
	output logic rdy_o,
	output logic rdy_oe_n,
	// Status
	output logic [9:0] wiper_position_register,
	output logic busy
);

	// ==========================================================
	// Link domain: capture on rising serial clock, valid in both modes
	logic [23:0] sreg_q;
	logic [7:0] lcnt_q;
	logic [7:0] base_q;
	logic rb_en_q;
	logic [23:0] rb_word_q;
	logic [7:0] ptr;
	logic [4:0] rb_idx;
	logic sdo_bit;

	always_ff @(posedge sclk or negedge rstn) begin // R18
		if (!rstn) begin
			sreg_q <= swc_pkg::WORD_RESET;
			lcnt_q <= 8'h00;
		end else if (!csn) begin
			sreg_q <= {sreg_q[22:0], sdi}; // R14
			lcnt_q <= lcnt_q + 8'h01;
		end
	end

	// Core-side base and readback word only change while chip select is high
	assign ptr = lcnt_q - base_q;
	assign rb_idx = 5'h17 - ptr[4:0];

	always_comb begin
		if (rb_en_q && (ptr < 8'h18)) begin
			sdo_bit = rb_word_q[rb_idx]; // R25
		end else begin
			sdo_bit = sreg_q[23]; // R20
		end
	end

	assign sdo_o = 1'b0;
	assign sdo_oe_n = csn | sdo_bit; // R13

	// ==========================================================
	// Pin synchronisers
	logic csn_s2, csn_s3;
	logic pre_s2, pre_s3;
	logic wp_s2;

	swc_sync u_csn_sync (
		.clk(clk),
		.rstn(rstn),
		.pin(csn),
		.sync_q(csn_s2)
	);
	swc_sync u_pre_sync (
		.clk(clk),
		.rstn(rstn),
		.pin(preset_strobe_n),
		.sync_q(pre_s2)
	);
	swc_sync u_wp_sync (
		.clk(clk),
		.rstn(rstn),
		.pin(write_protect_n),
		.sync_q(wp_s2)
	);

	// Third stage only feeds the edge detectors; idle-high reset avoids a false edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			csn_s3 <= 1'b1;
			pre_s3 <= 1'b1;
		end else begin
			csn_s3 <= csn_s2;
			pre_s3 <= pre_s2;
		end
	end

	logic frame_end;
	logic pre_fall;
	logic pre_rise;
	logic wp_active;

	assign frame_end = csn_s2 & ~csn_s3;
	assign pre_fall = ~pre_s2 & pre_s3;
	assign pre_rise = pre_s2 & ~pre_s3;
	assign wp_active = ~wp_s2;

	// ==========================================================
	// Frame acceptance
	logic [7:0] nbits;
	logic frame_ok;
	logic strobe_only;
	logic [23:0] word_q;
	logic word_valid_q;
	logic exec_q;
	swc_pkg::swc_state_t state_q;

	assign nbits = lcnt_q - base_q;
	assign frame_ok = (nbits != 8'h00) && ((nbits % 8'h18) == 8'h00); // R16
	assign strobe_only = (nbits == 8'h00);

	// Re-basing at every rise drops any stray bits, so misaligned counts restart
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			base_q <= 8'h00;
		end else if (frame_end) begin
			base_q <= lcnt_q; // R17
		end
	end

	// Last 24 bits of an accepted frame are this device's word
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			word_q <= swc_pkg::WORD_RESET;
			word_valid_q <= 1'b0;
			exec_q <= 1'b0;
		end else begin
			exec_q <= 1'b0;
			if (frame_end && (state_q == swc_pkg::ST_IDLE)) begin // R3
				if (frame_ok) begin
					word_q <= sreg_q; // R15 R21
					word_valid_q <= 1'b1;
					exec_q <= 1'b1;
				end else if (strobe_only && word_valid_q) begin
					exec_q <= 1'b1; // R9 R10
				end
			end
		end
	end

	logic [3:0] cmd;
	logic [3:0] addr;
	logic [15:0] data16;
	logic [9:0] wdata;

	assign cmd = word_q[swc_pkg::CMD_MSB:swc_pkg::CMD_LSB]; // R23
	assign addr = word_q[swc_pkg::ADDR_MSB:swc_pkg::ADDR_LSB];
	assign data16 = word_q[swc_pkg::DATA_MSB:0];
	assign wdata = word_q[swc_pkg::WIPER_W - 1:0];

	// ==========================================================
	// Nonvolatile store and store sequencer
	logic [15:0] nv_q [swc_pkg::NV_DEPTH];
	logic [swc_pkg::TMR_W - 1:0] tmr_q;
	logic [3:0] st_addr_q;
	logic [15:0] st_data_q;
	logic store_done;
	logic [9:0] wiper_q;
	logic done_q;

	assign store_done = (state_q == swc_pkg::ST_STORE) && (tmr_q == '0);
	assign busy = (state_q == swc_pkg::ST_STORE);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= swc_pkg::ST_POR;
			tmr_q <= '0;
			st_addr_q <= 4'h0;
			st_data_q <= swc_pkg::NV_RESET;
		end else begin
			case (state_q)
				swc_pkg::ST_POR: begin
					state_q <= swc_pkg::ST_IDLE;
				end
				swc_pkg::ST_IDLE: begin
					if (exec_q && !wp_active) begin
						if (cmd == swc_pkg::CMD_STORE_WIPER) begin
							state_q <= swc_pkg::ST_STORE; // R2
							tmr_q <= swc_pkg::TMR_W'(STORE_CYCLES - 1);
							st_addr_q <= 4'h0;
							st_data_q <= {6'h00, wiper_q};
						end else if (cmd == swc_pkg::CMD_STORE_DATA) begin
							state_q <= swc_pkg::ST_STORE;
							tmr_q <= swc_pkg::TMR_W'(STORE_CYCLES - 1);
							st_addr_q <= addr;
							st_data_q <= (addr == 4'h0) ? {6'h00, wiper_q} : data16;
						end
					end
				end
				swc_pkg::ST_STORE: begin
					if (tmr_q == '0) begin
						state_q <= swc_pkg::ST_IDLE; // R3
					end else begin
						tmr_q <= tmr_q - swc_pkg::TMR_W'(1);
					end
				end
				default: begin
					state_q <= swc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Flip-flops stand in for the cells; they return to midscale on reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < swc_pkg::NV_DEPTH; i++) begin
				nv_q[i] <= swc_pkg::NV_RESET; // R6
			end
		end else if (store_done) begin
			nv_q[st_addr_q] <= st_data_q;
		end
	end

	// ==========================================================
	// Wiper position register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wiper_q <= swc_pkg::WIPER_MIDSCALE;
		end else if (state_q == swc_pkg::ST_POR) begin
			wiper_q <= nv_q[0][9:0]; // R6
		end else if (pre_fall || !pre_s2) begin
			wiper_q <= swc_pkg::WIPER_MIDSCALE; // R8
		end else if (pre_rise) begin
			wiper_q <= nv_q[0][9:0]; // R8
		end else if (exec_q) begin
			case (cmd)
				swc_pkg::CMD_RESTORE, swc_pkg::CMD_RESET_LOAD: begin
					wiper_q <= nv_q[0][9:0]; // R7 R11
				end
				swc_pkg::CMD_WRITE_WIPER: begin
					if (!wp_active && addr == 4'h0) begin
						wiper_q <= wdata; // R1 R5
					end
				end
				swc_pkg::CMD_HALVE_A, swc_pkg::CMD_HALVE_B: begin
					if (!wp_active) begin
						wiper_q <= {1'b0, wiper_q[9:1]}; // R22
					end
				end
				swc_pkg::CMD_DEC_A, swc_pkg::CMD_DEC_B: begin
					if (!wp_active && wiper_q != 10'h000) begin
						wiper_q <= wiper_q - 10'h001; // R26
					end
				end
				swc_pkg::CMD_DOUBLE_A, swc_pkg::CMD_DOUBLE_B: begin
					if (!wp_active) begin
						wiper_q <= wiper_q[9] ? swc_pkg::WIPER_FULL : {wiper_q[8:0], 1'b0}; // R22
					end
				end
				swc_pkg::CMD_INC_A, swc_pkg::CMD_INC_B: begin
					if (!wp_active && wiper_q != swc_pkg::WIPER_FULL) begin
						wiper_q <= wiper_q + 10'h001; // R26
					end
				end
				default: begin
					wiper_q <= wiper_q; // R11
				end
			endcase
		end
	end

	assign wiper_position_register = wiper_q;

	// ==========================================================
	// Readback word, held for exactly the next frame
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rb_en_q <= 1'b0;
			rb_word_q <= swc_pkg::WORD_RESET;
		end else if (frame_end) begin
			rb_en_q <= 1'b0;
		end else if (exec_q) begin
			if (cmd == swc_pkg::CMD_READ_NV) begin
				rb_en_q <= 1'b1; // R19
				rb_word_q <= {cmd, addr, nv_q[addr]};
			end else if (cmd == swc_pkg::CMD_READ_WIPER) begin
				rb_en_q <= 1'b1; // R19
				rb_word_q <= {cmd, addr, 6'h00, wiper_q};
			end
		end
	end

	// ==========================================================
	// Ready pulse
	logic [3:0] rdy_cnt_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			done_q <= 1'b0;
		end else begin
			done_q <= store_done // R4
				|| (state_q == swc_pkg::ST_POR)
				|| pre_rise
				|| (exec_q && (cmd == swc_pkg::CMD_RESET_LOAD
					|| cmd == swc_pkg::CMD_READ_NV
					|| cmd == swc_pkg::CMD_READ_WIPER)); // R24
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdy_cnt_q <= 4'h0;
		end else if (done_q) begin
			rdy_cnt_q <= swc_pkg::RDY_PULSE_CYCLES; // R4
		end else if (rdy_cnt_q != 4'h0) begin
			rdy_cnt_q <= rdy_cnt_q - 4'h1;
		end
	end

	assign rdy_o = 1'b0;
	assign rdy_oe_n = (rdy_cnt_q == 4'h0);

endmodule : swc_wiper_cmd

// ==========================================================
// Two-flop synchroniser for one pin; only the second flop is read outside
module swc_sync #(
	parameter logic RST_VAL = 1'b1
) (
	// Core clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Pin and its synchronised copy
	input wire logic pin,
	output logic sync_q
);

	logic meta_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
		end
	end

endmodule : swc_sync

// ==== common/swc_pkg.sv ====
// Constants shared by the serial wiper command unit: frame layout, instruction
// codes, reset values and timing counts.
// Assumes a 250 MHz core clock; the serial clock is a separate domain.
package swc_pkg;

	// ==========================================================
	// Frame layout
	localparam int FRAME_BITS = 24;
	localparam int CMD_MSB = 23;
	localparam int CMD_LSB = 20;
	localparam int ADDR_MSB = 19;
	localparam int ADDR_LSB = 16;
	localparam int DATA_MSB = 15;
	localparam int WIPER_W = 10;
	localparam int NV_W = 16;
	localparam int NV_DEPTH = 16;
	localparam int CNT_W = 8;

	// ==========================================================
	// Instruction codes
	localparam logic [3:0] CMD_NOP = 4'h0;
	localparam logic [3:0] CMD_RESTORE = 4'h1;
	localparam logic [3:0] CMD_STORE_WIPER = 4'h2;
	localparam logic [3:0] CMD_STORE_DATA = 4'h3;
	localparam logic [3:0] CMD_HALVE_A = 4'h4;
	localparam logic [3:0] CMD_HALVE_B = 4'h5;
	localparam logic [3:0] CMD_DEC_A = 4'h6;
	localparam logic [3:0] CMD_DEC_B = 4'h7;
	localparam logic [3:0] CMD_RESET_LOAD = 4'h8;
	localparam logic [3:0] CMD_READ_NV = 4'h9;
	localparam logic [3:0] CMD_READ_WIPER = 4'hA;
	localparam logic [3:0] CMD_WRITE_WIPER = 4'hB;
	localparam logic [3:0] CMD_DOUBLE_A = 4'hC;
	localparam logic [3:0] CMD_DOUBLE_B = 4'hD;
	localparam logic [3:0] CMD_INC_A = 4'hE;
	localparam logic [3:0] CMD_INC_B = 4'hF;

	// ==========================================================
	// Reset values and full-scale code
	localparam logic [9:0] WIPER_MIDSCALE = 10'h200;
	localparam logic [9:0] WIPER_FULL = 10'h3FF;
	localparam logic [15:0] NV_RESET = 16'h0200;
	localparam logic [23:0] WORD_RESET = 24'h00_0000;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 250;
	localparam int STORE_TIME_MS = 25;
	localparam int STORE_CYCLES = STORE_TIME_MS * 1000 * CLK_MHZ;
	localparam int TMR_W = 23;
	localparam logic [3:0] RDY_PULSE_CYCLES = 4'h8;

	// ==========================================================
	// Execution states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STORE = 2'b01,
		ST_POR = 2'b10
	} swc_state_t;

endpackage : swc_pkg

// ==== testbench/swc_wiper_cmd_asserts.sv ====
// Port-level checks of the wiper command unit on the core clock.
// Assumes the link domain is visible here only through csn.
`timescale 1ns/10ps
module swc_wiper_cmd_chk #(
	parameter int STORE_CYCLES = 20
) (
	// Core
	input wire logic clk,
	input wire logic rstn,
	// Link
	input wire logic sclk,
	input wire logic csn,
	input wire logic sdi,
	input wire logic sdo_o,
	input wire logic sdo_oe_n,
	// Pins and status
	input wire logic preset_strobe_n,
	input wire logic write_protect_n,
	input wire logic rdy_o,
	input wire logic rdy_oe_n,
	input wire logic [9:0] wiper_position_register,
	input wire logic busy
);
	// ==========================================================
	// Store length counter, wide so a full 25 ms store never wraps
	int busy_cnt_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy_cnt_q <= 0;
		end else begin
			busy_cnt_q <= busy ? busy_cnt_q + 1 : 0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sdo_release_a: assert property (csn |-> sdo_oe_n)
		else $error("sdo driven while deselected");
	rdy_width_a: assert property ($fell(rdy_oe_n) |-> (!rdy_oe_n) [*8] ##1 rdy_oe_n)
		else $error("ready pulse width wrong");
	store_len_a: assert property ($fell(busy) |-> busy_cnt_q == STORE_CYCLES)
		else $error("store length wrong");
	store_done_a: assert property ($fell(busy) |-> ##[0:3] !rdy_oe_n)
		else $error("no ready pulse after store");
	store_quiet_a: assert property (busy |-> rdy_oe_n)
		else $error("ready pulsed during store");
	store_lock_a: assert property (busy && $past(busy) |-> $stable(wiper_position_register))
		else $error("wiper changed during store");
	preset_mid_a: assert property (!preset_strobe_n [*4] |-> wiper_position_register == 10'h200)
		else $error("preset did not force midscale");
	frame_edge_a: assert property ($changed(wiper_position_register) |-> $past(csn, 3))
		else $error("wiper changed inside a frame");
	cover property ($rose(busy));
	cover property ($fell(rdy_oe_n));
	cover property (!preset_strobe_n ##1 preset_strobe_n);
endmodule : swc_wiper_cmd_chk

bind swc_wiper_cmd swc_wiper_cmd_chk #(.STORE_CYCLES(STORE_CYCLES)) chk (.clk(clk), .rstn(rstn),
	.sclk(sclk), .csn(csn), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
	.preset_strobe_n(preset_strobe_n), .write_protect_n(write_protect_n), .rdy_o(rdy_o),
	.rdy_oe_n(rdy_oe_n), .wiper_position_register(wiper_position_register), .busy(busy));

// ==== testbench/swc_spi_host.sv ====
// Serial host model: mode 0 or mode 3 master with a 160 ns clock, free of the core clock.
// Assumes a pull-up on the open-drain data output.
`timescale 1ns/10ps
module swc_spi_host (
	// Serial pins
	output logic sclk,
	output logic csn,
	output logic sdi,
	input wire logic sdo_o,
	input wire logic sdo_oe_n
);
	// ==========================================================
	// Released line floats up through the pull-up
	wire sdo_line = sdo_oe_n ? 1'b1 : sdo_o;
	logic idle_hi = 1'b0;
	initial begin
		sclk = 1'b0;
		csn = 1'b1;
		sdi = 1'b0;
	end
	// Clock idles low in mode 0, high in mode 3, and stops between frames; n of zero is an empty strobe
	task automatic xfer(input logic [47:0] w, input int n, output logic [23:0] r);
		r = '0;
		csn = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			if (idle_hi) begin
				sclk = 1'b0;
			end
			sdi = w[i];
			#80 r = {r[22:0], sdo_line};
			sclk = 1'b1;
			#80;
			if (!idle_hi) begin
				sclk = 1'b0;
			end
		end
		#40 csn = 1'b1;
		sdi = ~sdi;
		#200;
	endtask : xfer
	// Mode 3 idles the clock high; bits still move on its rising edge
	task automatic set_mode(input logic hi);
		idle_hi = hi;
		sclk = hi;
		#200;
	endtask : set_mode
endmodule : swc_spi_host

// ==== testbench/testbench.sv ====
// Self-checking bench of the wiper command unit driven by the serial host model.
// Assumes a short store time parameter so the run stays brief.
`timescale 1ns/10ps
module testbench;
	// ==========================================================
	localparam int STORE_N = 2000;
	logic clk = 1'b0;
	logic rstn, preset_strobe_n, write_protect_n;
	logic sclk, csn, sdi, sdo_o, sdo_oe_n, rdy_o, rdy_oe_n, busy;
	logic [9:0] wiper;
	logic [9:0] e;
	logic [23:0] r;
	logic [3:0] codes [8] = '{4'hE, 4'hF, 4'h6, 4'h7, 4'h4, 4'h5, 4'hC, 4'hD};
	int n_mismatch = 0;
	int compares = 0;
	int n_rdy = 0;
	always #2 clk = ~clk;
	always @(negedge rdy_oe_n) n_rdy++;
	swc_wiper_cmd #(.STORE_CYCLES(STORE_N)) dut (.clk(clk), .rstn(rstn), .sclk(sclk),
		.csn(csn), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
		.preset_strobe_n(preset_strobe_n), .write_protect_n(write_protect_n), .rdy_o(rdy_o),
		.rdy_oe_n(rdy_oe_n), .wiper_position_register(wiper), .busy(busy));
	swc_spi_host host (.sclk(sclk), .csn(csn), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n));
	task automatic cmp_word(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_word
	task automatic cmp_wiper(input logic [9:0] exp);
		compares++;
		if (wiper !== exp) begin
			n_mismatch++;
			$display("mismatch wiper expected %h seen %h", exp, wiper);
		end
	endtask : cmp_wiper
	// Ten core cycles cover the four-cycle path from csn rise to wiper
	task automatic send(input logic [47:0] w, input int n);
		#1;
		host.xfer(w, n, r);
		repeat (10) @(posedge clk);
	endtask : send
	task automatic pins(input logic rs, input logic p, input logic wp);
		@(posedge clk);
		#1;
		rstn = rs;
		preset_strobe_n = p;
		write_protect_n = wp;
		repeat (12) @(posedge clk);
	endtask : pins
	task automatic wait_idle();
		for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clk);
		if (busy !== 1'b0) begin
			n_mismatch++;
			$display("mismatch busy expected 0 seen %b", busy);
		end
	endtask : wait_idle
	function automatic logic [9:0] step(input logic [3:0] c, input logic [9:0] v);
		case (c)
			4'h4, 4'h5: return v >> 1;
			4'h6, 4'h7: return (v == 10'h000) ? v : v - 10'h001;
			4'hC, 4'hD: return v[9] ? 10'h3FF : {v[8:0], 1'b0};
			default: return (v == 10'h3FF) ? v : v + 10'h001;
		endcase
	endfunction : step
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		rstn = 1'b0;
		preset_strobe_n = 1'b1;
		write_protect_n = 1'b1;
		repeat (2) @(posedge clk);
		pins(1'b1, 1'b1, 1'b1);
		cmp_wiper(10'h200);
		send(48'hB0_0100, 24);
		cmp_wiper(10'h100);
		send(48'hA0_0000, 24);
		cmp_word("echo", 24'hB0_0100, r);
		send(48'h00_0000, 24);
		cmp_word("readback", {8'hA0, 6'h00, 10'h100}, r);
		$display("test write and readback done");
		e = 10'h100;
		foreach (codes[i]) begin
			send({24'h00_0000, codes[i], 20'h0_0000}, 24);
			e = step(codes[i], e);
			cmp_wiper(e);
			send(48'h00_0000, 0);
			e = step(codes[i], e);
			cmp_wiper(e);
		end
		send(48'hB0_03FF, 24);
		send(48'hE0_0000, 24);
		cmp_wiper(10'h3FF);
		send(48'hB0_0000, 24);
		send(48'h60_0000, 24);
		cmp_wiper(10'h000);
		$display("test steps done");
		send(48'hB0_0155, 23);
		send(48'hB0_0155, 25);
		send(48'hB0_0155, 28);
		cmp_wiper(10'h000);
		send(48'hB001_11B0_0155, 48);
		cmp_wiper(10'h155);
		cmp_word("chain", 24'hB0_0111, r);
		$display("test frame length done");
		host.set_mode(1'b1);
		send(48'hA0_0000, 24);
		cmp_word("mode3 echo", 24'hB0_0155, r);
		send(48'hB0_02AA, 24);
		cmp_word("mode3 readback", 24'hA0_0155, r);
		cmp_wiper(10'h2AA);
		send(48'hB0_0155, 24);
		cmp_wiper(10'h155);
		host.set_mode(1'b0);
		$display("test clock mode 3 done");
		pins(1'b1, 1'b1, 1'b0);
		send(48'hB0_0000, 24);
		cmp_wiper(10'h155);
		send(48'h80_0000, 24);
		cmp_wiper(10'h200);
		send(48'h00_0000, 24);
		pins(1'b1, 1'b1, 1'b1);
		$display("test write protect done");
		send(48'hB0_0155, 24);
		send(48'h20_0000, 24);
		cmp_word("busy", 24'h00_0001, {23'h00_0000, busy});
		send(48'hB0_0000, 24);
		cmp_wiper(10'h155);
		wait_idle();
		send(48'hB0_0000, 24);
		send(48'h10_0000, 24);
		cmp_wiper(10'h155);
		send(48'h35_A5A5, 24);
		wait_idle();
		send(48'h95_0000, 24);
		send(48'h00_0000, 24);
		cmp_word("store readback", 24'h95_A5A5, r);
		pins(1'b1, 1'b0, 1'b1);
		cmp_wiper(10'h200);
		pins(1'b1, 1'b1, 1'b1);
		cmp_wiper(10'h155);
		$display("test store and preset done");
		pins(1'b0, 1'b1, 1'b1);
		pins(1'b1, 1'b1, 1'b1);
		cmp_wiper(10'h200);
		send(48'h00_0000, 0);
		cmp_wiper(10'h200);
		cmp_word("ready pulses", 24'h00_0009, 24'(n_rdy));
		$display("test second reset done");
		tally_and_finish();
	end
endmodule : testbench
